// file: logic/watchdog_cfg.sv
/*
  Watchdog timer with write-once option latches, reached over APB.
  Assumes crystal cycles are modelled by an enable pulse divided from pclk, that
  int_rst and stop strobes come from logic on pclk, and that pins are asynchronous.
*/
// Design decision made here: register access over APB.
`timescale 1ns/1ns
`default_nettype none
module watchdog_cfg
  import wdcfg_pkg::*;
#(
  parameter int XTAL_DIV = 32
) (
  // Clock and power-on reset.
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // APB slave.
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [wdcfg_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // System side, same clock.
  input  wire logic                   int_rst,
  input  wire logic [7:0]             reset_vector_lo,
  input  wire logic                   stop_exec,
  input  wire logic                   stop_wake,
  input  wire logic                   wake_by_lowvolt,
  // Asynchronous pin levels.
  input  wire logic                   monitor_mode,
  input  wire logic                   break_state,
  input  wire logic                   rst_pin_test_voltage,
  input  wire logic                   irq_pin_test_voltage,
  // Option and control outputs.
  output wdcfg_pkg::opt_t             opts,
  output logic                        osc_enable,
  output logic                        lowvolt_monitor_en,
  output logic                        serial_clk_is_bus,
  output logic                        stop_mode,
  output logic                        illegal_stop_rst,
  // Watchdog reset: open-drain reset pin and cause strobe.
  output logic                        rst_pin_o,
  output logic                        rst_pin_oe,
  output logic                        watchdog_cause_set
);
  import wdcfg_pkg::*;

  // Crystal divider state and tick.
  logic [15:0] div_r, div_nxt;
  logic        xtick;
  // Pin synchronisers.
  logic [3:0]  sync1_r, sync2_r;
  // Option latches and their used flags.
  opt_t        opt_r, opt_nxt;
  logic        used_a_r, used_a_nxt, used_b_r, used_b_nxt;
  logic        lvsel_used_r, lvsel_used_nxt;
  // Watchdog chain, reset pulse counter and power-on counter.
  logic [CHAIN_W-1:0] chain_r, chain_nxt;
  logic [12:0] rpulse_r, rpulse_nxt;
  logic [12:0] por_r, por_nxt;
  logic        cause_r, cause_nxt;
  // Stop mode state and recovery counter.
  logic        stop_r, stop_nxt, ill_r, ill_nxt;
  logic [12:0] rec_r, rec_nxt;
  // Bus decode.
  logic [31:0] prdata_r, prdata_nxt;
  logic        hit_a, hit_b, hit_s, mapped, wr_acc;
  logic        wd_off, wd_tick, timeout;

  // Decodes a byte address into a printed register index match.
  function automatic logic idx_hit(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
    idx_hit = (a == {idx, 2'b00});
  endfunction

  // Address decode; a service access only touches the watchdog, never the latches.
  always_comb begin
    hit_a  = idx_hit(paddr, IDX_LATCH_A);
    hit_b  = idx_hit(paddr, IDX_LATCH_B);
    hit_s  = idx_hit(paddr, IDX_SERVICE);
    mapped = hit_a | hit_b | hit_s;
    wr_acc = psel & penable & pwrite & pready;
  end

  // The slave never waits; unmapped addresses answer with an error.
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata  = prdata_r;

  // Read data is captured in the setup cycle so it comes from a flip-flop.
  always_comb begin
    prdata_nxt = prdata_r;
    if (psel & ~penable & ~pwrite) begin
      prdata_nxt = 32'h0000_0000;
      if (hit_a) begin
        prdata_nxt[A_OSC]  = opt_r.osc_run_in_stop;
        prdata_nxt[A_BAUD] = opt_r.serial_baud_clock_select;
      end
      if (hit_b) begin
        prdata_nxt[B_RATE]   = opt_r.watchdog_rate_select;
        prdata_nxt[B_LVSTOP] = opt_r.lowvolt_run_in_stop;
        prdata_nxt[B_LVRSTD] = 1'b0;
        prdata_nxt[B_LVPWRD] = 1'b0;
        prdata_nxt[B_LVSEL]  = 1'b0;
        prdata_nxt[B_SHORT_STOP_RECOVERY]  = opt_r.short_stop_recovery;
        prdata_nxt[B_STOPEN] = opt_r.stop_enable;
        prdata_nxt[B_WDDIS]  = opt_r.watchdog_disable;
      end
      if (hit_s) begin
        prdata_nxt[7:0] = reset_vector_lo;
      end
    end
  end

  // Divider producing one crystal tick per XTAL_DIV bus clocks.
  always_comb begin
    xtick   = (div_r == 16'(XTAL_DIV - 1));
    div_nxt = xtick ? 16'h0000 : div_r + 16'h0001;
  end

  // Option latches: first write after a reset sticks, later ones are dropped.
  always_comb begin
    opt_nxt        = opt_r;
    used_a_nxt     = used_a_r;
    used_b_nxt     = used_b_r;
    lvsel_used_nxt = lvsel_used_r;
    if (wr_acc & hit_a & ~used_a_r) begin
      opt_nxt.osc_run_in_stop          = pwdata[A_OSC];
      opt_nxt.serial_baud_clock_select = pwdata[A_BAUD];
      used_a_nxt = 1'b1;
    end
    if (wr_acc & hit_b & ~used_b_r) begin
      opt_nxt.watchdog_rate_select = pwdata[B_RATE];
      opt_nxt.lowvolt_run_in_stop  = pwdata[B_LVSTOP];
      opt_nxt.short_stop_recovery  = pwdata[B_SHORT_STOP_RECOVERY];
      opt_nxt.stop_enable          = pwdata[B_STOPEN];
      opt_nxt.watchdog_disable     = pwdata[B_WDDIS];
      used_b_nxt = 1'b1;
    end
    // The level select bit has no storage since it always reads zero, but its
    // write chance is spent once per power-on rather than once per reset.
    if (wr_acc & hit_b) begin
      lvsel_used_nxt = 1'b1;
    end
    // An internal reset clears options and used flags, not the level chance.
    if (int_rst) begin
      opt_nxt    = '0;
      used_a_nxt = 1'b0;
      used_b_nxt = 1'b0;
    end
  end

  // Watchdog disable from the option bit or from test voltage on the pins.
  always_comb begin
    wd_off = opt_r.watchdog_disable
           | (sync2_r[0] & (sync2_r[2] | sync2_r[3]))
           | (sync2_r[1] & sync2_r[2]);
    // The crystal input to the watchdog is gated off in stop mode.
    wd_tick = xtick & ~stop_r;
  end

  // Watchdog chain, timeout detect, reset pin pulse and power-on clear.
  always_comb begin
    chain_nxt  = chain_r;
    rpulse_nxt = rpulse_r;
    por_nxt    = por_r;
    timeout    = 1'b0;
    if (wd_tick) begin
      chain_nxt = chain_r + 18'h00001;
      // Short rate overflows the low 13 chain bits, long the whole chain.
      timeout = ~wd_off & (opt_r.watchdog_rate_select ? (&chain_r[SHORT_W-1:0])
                                                      : (&chain_r));
    end
    if (wr_acc & hit_s) begin
      chain_nxt[CHAIN_W-1:SVC_LO] = '0;
    end
    if (stop_exec & opt_r.stop_enable) begin
      chain_nxt[PRE_W-1:0] = '0;
    end
    if (xtick & (por_r != POR_CLR)) begin
      por_nxt = por_r + 13'h0001;
    end
    if (xtick & (por_r == POR_CLR - 13'h0001)) begin
      chain_nxt[PRE_W-1:0] = '0;
    end
    if (int_rst) begin
      chain_nxt = '0;
    end
    if (timeout) begin
      rpulse_nxt = WD_RST_TICKS;
    end else if (xtick & (rpulse_r != 13'h0000)) begin
      rpulse_nxt = rpulse_r - 13'h0001;
    end
    // The cause strobe is the only notice; no interrupt request exists.
    cause_nxt = timeout;
  end

  // Stop entry, illegal-opcode reset and stop recovery delay.
  always_comb begin
    stop_nxt = stop_r;
    ill_nxt  = 1'b0;
    rec_nxt  = rec_r;
    if (stop_exec & ~stop_r) begin
      if (opt_r.stop_enable) begin
        stop_nxt = 1'b1;
      end else begin
        ill_nxt = 1'b1;
      end
    end
    if (stop_r & stop_wake & (rec_r == 13'h0000)) begin
      rec_nxt = (opt_r.short_stop_recovery & ~wake_by_lowvolt) ? REC_SHORT
                                                               : REC_LONG;
    end else if (xtick & (rec_r != 13'h0000)) begin
      rec_nxt = rec_r - 13'h0001;
      if (rec_r == 13'h0001) begin
        stop_nxt = 1'b0;
      end
    end
    if (int_rst) begin
      stop_nxt = 1'b0;
      rec_nxt  = 13'h0000;
    end
  end

  // All state registers; presetn is the power-on reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r        <= 16'h0000;
      sync1_r      <= 4'h0;
      sync2_r      <= 4'h0;
      opt_r        <= '0;
      used_a_r     <= 1'b0;
      used_b_r     <= 1'b0;
      lvsel_used_r <= 1'b0;
      chain_r      <= '0;
      rpulse_r     <= 13'h0000;
      por_r        <= 13'h0000;
      cause_r      <= 1'b0;
      stop_r       <= 1'b0;
      ill_r        <= 1'b0;
      rec_r        <= 13'h0000;
      prdata_r     <= 32'h0000_0000;
    end else begin
      div_r        <= div_nxt;
      sync1_r      <= {irq_pin_test_voltage, rst_pin_test_voltage, break_state, monitor_mode};
      sync2_r      <= sync1_r;
      opt_r        <= opt_nxt;
      used_a_r     <= used_a_nxt;
      used_b_r     <= used_b_nxt;
      lvsel_used_r <= lvsel_used_nxt;
      chain_r      <= chain_nxt;
      rpulse_r     <= rpulse_nxt;
      por_r        <= por_nxt;
      cause_r      <= cause_nxt;
      stop_r       <= stop_nxt;
      ill_r        <= ill_nxt;
      rec_r        <= rec_nxt;
      prdata_r     <= prdata_nxt;
    end
  end

  // Derived outputs; the reset pin is open drain and only ever pulled low.
  assign opts               = opt_r;
  assign stop_mode          = stop_r;
  assign osc_enable         = ~stop_r | opt_r.osc_run_in_stop;
  assign lowvolt_monitor_en = ~stop_r | opt_r.lowvolt_run_in_stop;
  assign serial_clk_is_bus  = opt_r.serial_baud_clock_select;
  assign illegal_stop_rst   = ill_r;
  assign rst_pin_o          = 1'b0;
  assign rst_pin_oe         = (rpulse_r != 13'h0000);
  assign watchdog_cause_set = cause_r;

  // A second write to used latch B must not change the options.
  property p_write_once;
    @(posedge pclk) disable iff (!presetn)
    (wr_acc & hit_b & used_b_r & ~int_rst) |=> $stable(opt_r);
  endproperty
  a_write_once: assert property (p_write_once) else $error("latch rewritten");

  property p_int_rst_clears;
    @(posedge pclk) disable iff (!presetn)
    int_rst |=> (opt_r == '0) && (chain_r == '0) && !used_a_r && !used_b_r;
  endproperty
  a_int_rst_clears: assert property (p_int_rst_clears) else $error("reset left state");

  property p_lvsel_por;
    @(posedge pclk) disable iff (!presetn)
    lvsel_used_r |=> lvsel_used_r;
  endproperty
  a_lvsel_por: assert property (p_lvsel_por) else $error("level chance restored");

  property p_svc_clear;
    @(posedge pclk) disable iff (!presetn)
    (wr_acc & hit_s & ~int_rst) |=> (chain_r[CHAIN_W-1:SVC_LO+1] == '0);
  endproperty
  a_svc_clear: assert property (p_svc_clear) else $error("service missed");

  // An accepted stop instruction restarts the prescaler from zero.
  property p_stop_clears;
    @(posedge pclk) disable iff (!presetn)
    (stop_exec & opt_r.stop_enable & ~int_rst) |=> (chain_r[PRE_W-1:0] == '0);
  endproperty
  a_stop_clears: assert property (p_stop_clears) else $error("stop kept prescaler");

  // The power-on counter clears the prescaler once at its final tick.
  property p_por_clear;
    @(posedge pclk) disable iff (!presetn)
    (xtick & (por_r == POR_CLR - 13'h0001)) |=> (chain_r[PRE_W-1:0] == '0);
  endproperty
  a_por_clear: assert property (p_por_clear) else $error("power-on clear missed");

  property p_disabled_quiet;
    @(posedge pclk) disable iff (!presetn)
    opt_r.watchdog_disable |-> !timeout;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled timeout");

  property p_pulse_len;
    @(posedge pclk) disable iff (!presetn)
    timeout |=> (rpulse_r == 13'h0020) && rst_pin_oe && watchdog_cause_set;
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("bad reset pulse");

  property p_illegal_stop;
    @(posedge pclk) disable iff (!presetn)
    (stop_exec & ~stop_r & ~opt_r.stop_enable) |=> illegal_stop_rst && !stop_mode;
  endproperty
  a_illegal_stop: assert property (p_illegal_stop) else $error("stop not refused");

  property p_lowvolt_long;
    @(posedge pclk) disable iff (!presetn)
    (stop_r & stop_wake & wake_by_lowvolt & (rec_r == 13'h0000) & ~int_rst)
      |=> (rec_r == 13'h1000);
  endproperty
  a_lowvolt_long: assert property (p_lowvolt_long) else $error("short lv recovery");

  property p_osc_stop;
    @(posedge pclk) disable iff (!presetn)
    (stop_mode & ~opt_r.osc_run_in_stop) |-> !osc_enable;
  endproperty
  a_osc_stop: assert property (p_osc_stop) else $error("oscillator ran");

  property p_svc_read;
    @(posedge pclk) disable iff (!presetn)
    (psel & ~penable & ~pwrite & hit_s) |=> (prdata[7:0] == $past(reset_vector_lo));
  endproperty
  a_svc_read: assert property (p_svc_read) else $error("service read wrong");

  c_timeout: cover property (@(posedge pclk) disable iff (!presetn) timeout);
  c_rewrite: cover property (@(posedge pclk) disable iff (!presetn) wr_acc & hit_a & used_a_r);
  c_recover: cover property (@(posedge pclk) disable iff (!presetn) $fell(stop_r));
endmodule
`default_nettype wire

// file: logic/wdcfg_pkg.sv
/*
  Constants and types for the watchdog with write-once option latches.
  Assumes a 32-bit APB slave whose register indices map to byte address index*4.
*/
`default_nettype none
package wdcfg_pkg;
  // Register indices as printed; byte address is four times the index.
  localparam logic [15:0] IDX_LATCH_A = 16'h001E;
  localparam logic [15:0] IDX_LATCH_B = 16'h001F;
  localparam logic [15:0] IDX_SERVICE = 16'hFFFF;
  localparam int          ADDR_W      = 18;
  // Field positions in option latch A.
  localparam int A_OSC  = 1;
  localparam int A_BAUD = 0;
  // Field positions in option latch B.
  localparam int B_RATE   = 7;
  localparam int B_LVSTOP = 6;
  localparam int B_LVRSTD = 5;
  localparam int B_LVPWRD = 4;
  localparam int B_LVSEL  = 3;
  localparam int B_SHORT_STOP_RECOVERY  = 2;
  localparam int B_STOPEN = 1;
  localparam int B_WDDIS  = 0;
  // Watchdog chain: 12-bit prescaler under a 6-bit counter.
  localparam int PRE_W   = 12;
  localparam int CNT_W   = 6;
  localparam int CHAIN_W = PRE_W + CNT_W;
  localparam int SHORT_W = 13;
  localparam int SVC_LO  = 4;
  // Crystal cycle counts.
  localparam logic [12:0] WD_RST_TICKS = 13'h0020;
  localparam logic [12:0] REC_SHORT    = 13'h0020;
  localparam logic [12:0] REC_LONG     = 13'h1000;
  localparam logic [12:0] POR_CLR      = 13'h1000;
  // Option bits held by the latches; the low-voltage reset, power and level bits are absent.
  typedef struct packed {
    logic osc_run_in_stop;
    logic serial_baud_clock_select;
    logic watchdog_rate_select;
    logic lowvolt_run_in_stop;
    logic short_stop_recovery;
    logic stop_enable;
    logic watchdog_disable;
  } opt_t;
endpackage
`default_nettype wire

// file: verification/watchdog_with_write_once_config_test.sv
/*
  Self-checking bench for the watchdog with write-once option latches.
  Assumes the design files are compiled first and that the design runs with
  one crystal tick per pclk cycle, so watchdog and recovery counts stay short.
*/
`timescale 1ns/1ns
`default_nettype none
module watchdog_with_write_once_config_test;
  import wdcfg_pkg::*;

  // Byte addresses are four times the register index.
  localparam logic [17:0] ADR_A = {IDX_LATCH_A, 2'b00};
  localparam logic [17:0] ADR_B = {IDX_LATCH_B, 2'b00};
  localparam logic [17:0] SVC   = {IDX_SERVICE, 2'b00};
  localparam logic [17:0] BAD   = 18'h00100;

  // Clock, reset and bus signals.
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        err;
  // System side and pin levels.
  logic        int_rst, stop_exec, stop_wake, wake_by_lowvolt;
  logic        monitor_mode, break_state, rst_pin_test_voltage, irq_pin_test_voltage;
  logic [7:0]  reset_vector_lo;
  // Observed outputs.
  opt_t        opts;
  logic        osc_enable, lowvolt_monitor_en, serial_clk_is_bus, stop_mode;
  logic        illegal_stop_rst, rst_pin_o, rst_pin_oe, watchdog_cause_set;
  // Bookkeeping.
  int          fails, samples_checked, cyc, n, t0;

  watchdog_cfg #(.XTAL_DIV(1)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .int_rst(int_rst),
    .reset_vector_lo(reset_vector_lo), .stop_exec(stop_exec),
    .stop_wake(stop_wake), .wake_by_lowvolt(wake_by_lowvolt),
    .monitor_mode(monitor_mode), .break_state(break_state),
    .rst_pin_test_voltage(rst_pin_test_voltage),
    .irq_pin_test_voltage(irq_pin_test_voltage), .opts(opts),
    .osc_enable(osc_enable), .lowvolt_monitor_en(lowvolt_monitor_en),
    .serial_clk_is_bus(serial_clk_is_bus), .stop_mode(stop_mode),
    .illegal_stop_rst(illegal_stop_rst), .rst_pin_o(rst_pin_o),
    .rst_pin_oe(rst_pin_oe), .watchdog_cause_set(watchdog_cause_set)
  );

  // A 4 ns clock.
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // The ceiling sits well above the roughly 50k cycles the tests need.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 70000) begin
      fails++;
      stop_test();
    end
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Compares two values; case equality keeps unknowns from matching.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t ns: got %0h, expected %0h", $time, got, exp);
    end
  endtask

  // Checks a measured cycle count against a window.
  task automatic rng(input int got, input int lo, input int hi);
    samples_checked++;
    if (got < lo || got > hi) begin
      fails++;
      $display("unexpected at %0t ns: got %0h, expected %0h..%0h", $time, got, lo, hi);
    end
  endtask

  // One bus transfer; the request holds until pready is seen high.
  task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait that never sees pready.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Let the write land before anything is looked at.
    @(posedge pclk);
    #1;
  endtask

  // Internal reset for one cycle.
  task automatic reset_int();
    @(posedge pclk);
    int_rst <= 1'b1;
    @(posedge pclk);
    int_rst <= 1'b0;
    @(posedge pclk);
    #1;
  endtask

  // A one-cycle stop or wake pulse, with the low-voltage qualifier.
  task automatic pulse(input logic wake, input logic lv);
    @(posedge pclk);
    stop_exec       <= ~wake;
    stop_wake       <= wake;
    wake_by_lowvolt <= lv;
    @(posedge pclk);
    stop_exec <= 1'b0;
    stop_wake <= 1'b0;
    #1;
  endtask

  // Event selector for the bounded waits below.
  function automatic logic probe(input int s);
    case (s)
      0:       return watchdog_cause_set;
      1:       return ~stop_mode;
      2:       return illegal_stop_rst;
      3:       return ~rst_pin_oe;
      default: return rst_pin_oe;
    endcase
  endfunction

  // Counts cycles until the chosen event, giving up at the limit.
  task automatic wait_on(input int s, input int lim, output int cnt);
    cnt = 0;
    while (probe(s) !== 1'b1 && cnt < lim) begin
      @(posedge pclk);
      #1;
      cnt++;
    end
  endtask

  // Main sequence.
  initial begin
    {presetn, psel, penable, pwrite, int_rst, stop_exec, stop_wake} = 7'h00;
    {wake_by_lowvolt, monitor_mode, break_state} = 3'h0;
    {rst_pin_test_voltage, irq_pin_test_voltage} = 2'h0;
    paddr = 18'h00000;
    pwdata = 32'h00000000;
    reset_vector_lo = 8'h3C;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    // Power-on defaults, then two writes per latch, the second one dropped.
    chk({25'h0, opts}, 32'h0);
    apb(1'b0, ADR_A, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, ADR_B, 32'hFF);
    apb(1'b0, ADR_B, 32'h0);
    chk(rd, 32'hC7);
    apb(1'b1, ADR_B, 32'h00);
    apb(1'b0, ADR_B, 32'h0);
    chk(rd, 32'hC7);
    apb(1'b1, ADR_A, 32'h03);
    apb(1'b1, ADR_A, 32'h00);
    apb(1'b0, ADR_A, 32'h0);
    chk(rd, 32'h03);
    chk(serial_clk_is_bus, 1'b1);
    apb(1'b0, SVC, 32'h0);
    chk(rd, 32'h3C);
    apb(1'b0, BAD, 32'h0);
    chk(err, 1'b1);
    reset_int();
    chk({25'h0, opts}, 32'h0);
    apb(1'b1, ADR_A, 32'h00);
    chk(serial_clk_is_bus, 1'b0);
    // Stop while the instruction is still disabled.
    pulse(1'b0, 1'b0);
    wait_on(2, 4, n);
    rng(n, 0, 3);
    chk(stop_mode, 1'b0);
    // Stop and recovery; the second pass wakes by low voltage, the third
    // stops the oscillator. Short recovery is only set with the oscillator kept running.
    for (int k = 0; k < 3; k++) begin
      reset_int();
      apb(1'b1, ADR_A, (k == 2) ? 32'h00 : 32'h02);
      apb(1'b1, ADR_B, (k == 0) ? 32'h46 : ((k == 1) ? 32'h06 : 32'h02));
      pulse(1'b0, k == 1);
      chk(stop_mode, 1'b1);
      chk(osc_enable, k != 2);
      chk(lowvolt_monitor_en, k == 0);
      pulse(1'b1, k == 1);
      wait_on(1, 5000, n);
      rng(n, k ? 4093 : 29, k ? 4099 : 35);
    end
    // Short timeout; a mid-period service restarts it, a read does not.
    reset_int();
    apb(1'b1, ADR_B, 32'h80);
    apb(1'b1, SVC, 32'h0);
    repeat (4000) @(posedge pclk);
    apb(1'b1, SVC, 32'h5A);
    t0 = cyc;
    repeat (3000) @(posedge pclk);
    apb(1'b0, SVC, 32'h0);
    wait_on(0, 9000, n);
    rng(cyc - t0, 8170, 8196);
    wait_on(4, 3, n);
    wait_on(3, 100, n);
    rng(n, 32, 32);
    chk(rst_pin_o, 1'b0);
    // No timeout when disabled or under test voltage.
    for (int k = 0; k < 3; k++) begin
      reset_int();
      @(posedge pclk);
      monitor_mode         <= (k == 1);
      irq_pin_test_voltage <= (k == 1);
      break_state          <= (k == 2);
      rst_pin_test_voltage <= (k == 2);
      apb(1'b1, ADR_B, (k == 0) ? 32'h81 : 32'h80);
      apb(1'b1, SVC, 32'h0);
      wait_on(0, 9000, n);
      rng(n, 9000, 9000);
    end
    stop_test();
  end
endmodule
`default_nettype wire
